/* File: verilog/paux_pkg.sv */
// Functional notes
// - eight window discriminators pulse on a peak between own levels.
// - each window discriminator pulse is a fixed 100 ns wide.
// - a window pulse comes just after the shaped pulse starts to fall.
// - the input count pulse is exactly one clock wide.
// - the input count pulse is raised as the shaped pulse starts to rise.
// - the fast channel separately flags two pulses as close as 120 ns.
// - the trigger is high while searching; its fall marks the peak.
// - the detector reset signal is high for the whole lockout.
// - a fast hit starts the one-shot, held while pile-up is checked.
// - pile-up is flagged at the end of the last one-shot, if it occurred.
// - an event is accepted only if the gate is true at the trigger fall.
// - each aux output follows one software-selected internal signal.
// - software assigns each aux input to one internal function.
// - the serial host link uses only data lines, with no handshake; the code has an AHB-Lite register port instead.
// - the clock is 20 MHz or 80 MHz; cycle widths scale with it.
package paux_pkg;
    // ****************************************************************
    // register map, word aligned
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_AUXSEL   = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_THR_BASE = 8'h20;
    localparam int         NUM_WIN       = 8;
    localparam int         LEVEL_W       = 16;
    // ****************************************************************
    // fields
    // ****************************************************************
    localparam int CTRL_CLK80_BIT   = 0;
    localparam int CTRL_LOCKOUT_LSB = 8;
    localparam int CTRL_ONESHOT_LSB = 20;
    localparam logic [31:0] CTRL_RESET = 32'h0064_0101;
    localparam int AUXSEL_W = 3;
    localparam int IRQ_W    = 4;
    localparam int IRQ_ACCEPT = 0;
    localparam int IRQ_REJECT = 1;
    localparam int IRQ_PILEUP = 2;
    localparam int IRQ_DETRST = 3;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int WIN_PULSE_NS = 100;
    localparam int CLK80_MHZ    = 80;
    localparam int CLK20_MHZ    = 20;
    localparam logic [3:0] WIN_CYC80 = 4'((WIN_PULSE_NS*CLK80_MHZ)/1000);
    localparam logic [3:0] WIN_CYC20 = 4'((WIN_PULSE_NS*CLK20_MHZ)/1000);
    // ****************************************************************
    // auxiliary selections
    // ****************************************************************
    typedef enum logic [2:0] {
        PAUX_OUT_COUNT   = 3'b000,
        PAUX_OUT_TRIG    = 3'b001,
        PAUX_OUT_DETRST  = 3'b010,
        PAUX_OUT_ONESHOT = 3'b011,
        PAUX_OUT_PILEUP  = 3'b100,
        PAUX_OUT_WIN0    = 3'b101,
        PAUX_OUT_LOW     = 3'b110
    } paux_outsel_type;
    typedef enum logic [1:0] {
        PAUX_IN_NONE   = 2'b00,
        PAUX_IN_GATE   = 2'b01,
        PAUX_IN_DETRST = 2'b10
    } paux_insel_type;
    typedef struct packed {
        logic                fast_hit;
        logic                peak_found;
        logic                preamp_reset;
        logic [LEVEL_W-1:0]  peak_level;
    } paux_event_type;
endpackage

/* File: verilog/paux_pulse.sv */
`timescale 1ns/1ps
// fixed width pulse stretcher, retriggerable
module paux_pulse (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // control
    input  wire logic       fire,
    input  wire logic [3:0] width,
    // output
    output logic            pulse
);
    logic [3:0] count;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= 4'h0;
        end else if (fire) begin
            count <= width;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
        end
    end
    assign pulse = (count != 4'h0);
endmodule

/* File: verilog/paux_outmux.sv */
`timescale 1ns/1ps
// glitch-free source switch: waits for both old and new low
module paux_outmux (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // sources and select
    input  wire logic [7:0] sources,
    input  wire logic [2:0] select,
    // pin
    output logic            aux_out
);
    logic [2:0] active_sel;
    logic       next_out;
    wire        old_low = !sources[active_sel];
    wire        new_low = !sources[select];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_sel <= 3'h6;
        end else if (old_low && new_low) begin
            active_sel <= select;
        end
    end
    assign next_out = sources[active_sel];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aux_out <= 1'b0;
        end else begin
            aux_out <= next_out;
        end
    end
endmodule

/* File: verilog/paux_top.sv */
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module paux_top
    import paux_pkg::*;
#(
    parameter int NUM_AUX = 2
) (
    // ahb-lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // pulse processor events
    input  wire paux_pkg::paux_event_type evt,
    // auxiliary pins
    input  wire logic [1:0]  aux_in,
    output logic [1:0]       aux_out,
    output logic [7:0]       win_out,
    // internal signals and interrupt
    output logic             input_count_pulse,
    output logic             event_accept,
    output logic             irq
);
    import paux_pkg::*;

    // ****************************************************************
    // parameter checks
    // ****************************************************************
    generate
        if (NUM_AUX != 2) begin : g_bad_aux
            $error("paux_top serves two auxiliary lines");
        end
        // a zero count would leave the window pulses dead
        if (WIN_CYC20 == 4'h0) begin : g_bad_width
            $error("window pulse shorter than one clock");
        end
    endgenerate

    // ****************************************************************
    // bus slave
    // ****************************************************************
    logic [31:0]           ctrl;
    logic [2*AUXSEL_W+3:0] auxsel;
    logic [IRQ_W-1:0]      irq_stat;
    logic [IRQ_W-1:0]      irq_mask;
    logic [LEVEL_W-1:0]    lower_level_threshold [NUM_WIN];
    logic [LEVEL_W-1:0]    upper_level_threshold [NUM_WIN];
    logic                  wr_pend;
    logic [7:0]            wr_addr;

    // threshold words fill one aligned block, one word per window
    function automatic logic in_thr_block(input logic [7:0] addr);
        return (addr >= ADDR_THR_BASE) &&
               (addr < ADDR_THR_BASE + 8'(4 * NUM_WIN));
    endfunction

    wire  xfer     = hsel && hready && htrans[1];
    wire  is_thr   = in_thr_block(wr_addr);
    wire  [2:0] thr_idx = wr_addr[4:2];
    // no wait states: every register answers at once
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= xfer && hwrite;
            if (xfer) wr_addr <= haddr;
        end
    end

    // ctrl and auxsel are live: ctrl and aux input routing act at once, an aux output select once its old and new sources are low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl   <= CTRL_RESET;
            auxsel <= '0;
            irq_mask <= '0;
        end else if (wr_pend) begin
            if (wr_addr == ADDR_CTRL)     ctrl     <= hwdata;
            if (wr_addr == ADDR_AUXSEL)   auxsel   <= hwdata[2*AUXSEL_W+3:0];
            if (wr_addr == ADDR_IRQ_MASK) irq_mask <= hwdata[IRQ_W-1:0];
        end
    end

    // one word holds both levels of a window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_WIN; i++) begin
                lower_level_threshold[i] <= '0;
                upper_level_threshold[i] <= '1;
            end
        end else if (wr_pend && is_thr) begin
            lower_level_threshold[thr_idx] <= hwdata[LEVEL_W-1:0];
            upper_level_threshold[thr_idx] <= hwdata[31:16];
        end
    end

    // ****************************************************************
    // input synchronisers and aux input routing
    // ****************************************************************
    // two flops: the aux pins run free of hclk
    logic [1:0] aux_meta;
    logic [1:0] aux_sync;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aux_meta <= 2'b00;
            aux_sync <= 2'b00;
        end else begin
            aux_meta <= aux_in;
            aux_sync <= aux_meta;
        end
    end
    wire [1:0] in_sel0 = auxsel[7:6];
    wire [1:0] in_sel1 = auxsel[9:8];
    wire gate_used = (in_sel0 == PAUX_IN_GATE) || (in_sel1 == PAUX_IN_GATE);
    wire gate_lvl  = (in_sel0 == PAUX_IN_GATE && aux_sync[0]) ||
                     (in_sel1 == PAUX_IN_GATE && aux_sync[1]);
    wire ext_reset = (in_sel0 == PAUX_IN_DETRST && aux_sync[0]) ||
                     (in_sel1 == PAUX_IN_DETRST && aux_sync[1]);

    // ****************************************************************
    // event timing
    // ****************************************************************
    wire        clk80    = ctrl[CTRL_CLK80_BIT];
    wire [3:0]  win_cyc  = clk80 ? WIN_CYC80 : WIN_CYC20;
    wire [11:0] lockout  = ctrl[CTRL_LOCKOUT_LSB +: 12];
    wire [11:0] one_len  = ctrl[CTRL_ONESHOT_LSB +: 12];
    logic trig;
    logic det_reset;
    logic [11:0] lock_cnt;
    logic [11:0] one_cnt;
    logic pile_seen;
    logic pileup;
    logic peak_fall;
    logic [LEVEL_W-1:0] peak_hold;

    // one cycle per fast hit outside detector reset, hits one idle clock apart give distinct pulses
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            input_count_pulse <= 1'b0;
        end else begin
            input_count_pulse <= evt.fast_hit && !det_reset;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig <= 1'b0;
        end else if (evt.fast_hit && !det_reset) begin
            trig <= 1'b1;
        end else if (evt.peak_found || det_reset) begin
            trig <= 1'b0;
        end
    end
    assign peak_fall = trig && (evt.peak_found || det_reset) &&
                       !(evt.fast_hit && !det_reset);

    // a preamp reset during lockout restarts the count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_cnt <= 12'h000;
        end else if (evt.preamp_reset || ext_reset) begin
            lock_cnt <= lockout;
        end else if (lock_cnt != 12'h000) begin
            lock_cnt <= lock_cnt - 12'h001;
        end
    end
    assign det_reset = lock_cnt != 12'h000;

    // retriggered by each hit; pile-up remembered until the window ends
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            one_cnt   <= 12'h000;
            pile_seen <= 1'b0;
            pileup    <= 1'b0;
        end else begin
            pileup <= 1'b0;
            if (evt.fast_hit) begin
                one_cnt <= one_len;
                if (one_cnt != 12'h000) pile_seen <= 1'b1;
            end else if (one_cnt == 12'h001) begin
                one_cnt   <= 12'h000;
                pileup    <= pile_seen;
                pile_seen <= 1'b0;
            end else if (one_cnt != 12'h000) begin
                one_cnt <= one_cnt - 12'h001;
            end
        end
    end

    // a fall forced by a detector reset is an abort, not an event
    wire peak_taken = peak_fall && evt.peak_found;

    // gate sampled at the trigger fall; no gate routed means accept
    logic event_reject;
    logic win_fire;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_accept <= 1'b0;
            event_reject <= 1'b0;
            peak_hold    <= '0;
            win_fire     <= 1'b0;
        end else begin
            event_accept <= peak_taken && (!gate_used || gate_lvl);
            event_reject <= peak_taken && gate_used && !gate_lvl;
            win_fire     <= peak_taken;
            if (peak_fall) peak_hold <= evt.peak_level;
        end
    end

    // ****************************************************************
    // window discriminators
    // ****************************************************************
    // retriggerable: a peak inside a pulse restarts its width
    genvar w;
    generate
        for (w = 0; w < NUM_WIN; w++) begin : g_win
            wire in_win = win_fire &&
                peak_hold >= lower_level_threshold[w] &&
                peak_hold <= upper_level_threshold[w];
            paux_pulse u_pulse (
                .hclk    (hclk),
                .hresetn (hresetn),
                .fire    (in_win),
                .width   (win_cyc),
                .pulse   (win_out[w])
            );
        end
    endgenerate

    // ****************************************************************
    // auxiliary outputs
    // ****************************************************************
    // codes 6 and 7 stay low, a quiet parking place
    wire [7:0] out_src = {1'b0, 1'b0, win_out[0], pileup,
                          (one_cnt != 12'h000), det_reset, trig,
                          input_count_pulse};
    genvar a;
    generate
        for (a = 0; a < 2; a++) begin : g_aux
            paux_outmux u_mux (
                .hclk    (hclk),
                .hresetn (hresetn),
                .sources (out_src),
                .select  (auxsel[a*AUXSEL_W +: AUXSEL_W]),
                .aux_out (aux_out[a])
            );
        end
    endgenerate

    // ****************************************************************
    // interrupts, write one to clear, set wins
    // ****************************************************************
    // an event in the clearing cycle stays set
    wire [IRQ_W-1:0] irq_set = {evt.preamp_reset, pileup,
                                event_reject, event_accept};
    wire [IRQ_W-1:0] irq_clr = (wr_pend && wr_addr == ADDR_IRQ_STAT) ?
                               hwdata[IRQ_W-1:0] : '0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end
    assign irq = |(irq_stat & irq_mask);

    // ****************************************************************
    // read data; hrdata is registered and valid in the data phase
    // ****************************************************************
    // data taken in the address phase; unmapped reads give zero
    logic [31:0] next_rdata;
    wire  [7:0]  ra = haddr;
    wire  [2:0]  ri = ra[4:2];
    wire  [31:0] status_word = {25'h0, pile_seen, (one_cnt != 12'h000),
                                det_reset, trig, aux_sync, 1'b0};
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (ra == ADDR_CTRL) next_rdata = ctrl;
        else if (ra == ADDR_AUXSEL) next_rdata = {22'h0, auxsel};
        else if (ra == ADDR_STATUS) next_rdata = status_word;
        else if (ra == ADDR_IRQ_STAT) next_rdata = {28'h0, irq_stat};
        else if (ra == ADDR_IRQ_MASK) next_rdata = {28'h0, irq_mask};
        else if (in_thr_block(ra))
            next_rdata = {upper_level_threshold[ri],
                          lower_level_threshold[ri]};
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (xfer && !hwrite) begin
            hrdata <= next_rdata;
        end
    end
endmodule

/* File: verif/paux_asserts.sv */
`timescale 1ns/1ps
// ****************************************************************
// port checker
// ****************************************************************
module paux_asserts (
    // clock and reset
    input wire logic                    hclk,
    input wire logic                    hresetn,
    // watched ports
    input wire paux_pkg::paux_event_type evt,
    input wire logic                    hreadyout,
    input wire logic                    hresp,
    input wire logic [7:0]              win_out,
    input wire logic                    input_count_pulse,
    input wire logic                    event_accept
);
    import paux_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_count_rise;
        evt.fast_hit |=> input_count_pulse;
    endproperty
    a_count_rise: assert property (p_count_rise)
        else $error("count pulse missing after fast hit");
    property p_count_width;
        input_count_pulse && !evt.fast_hit |=> !input_count_pulse;
    endproperty
    a_count_width: assert property (p_count_width)
        else $error("count pulse wider than one clock");
    // two hits one idle clock apart must both be flagged
    property p_count_pair;
        evt.fast_hit ##1 !evt.fast_hit ##1 evt.fast_hit
            |=> input_count_pulse && $past(input_count_pulse, 2);
    endproperty
    a_count_pair: assert property (p_count_pair)
        else $error("close pair of hits not both flagged");
    property p_win_width;
        $rose(win_out[0]) |-> win_out[0] [*8] ##1 !win_out[0];
    endproperty
    a_win_width: assert property (p_win_width)
        else $error("window pulse width wrong");
    property p_win_after_peak;
        $rose(win_out[0]) |-> $past(evt.peak_found, 2);
    endproperty
    a_win_after_peak: assert property (p_win_after_peak)
        else $error("window pulse not two clocks after peak");
    property p_accept_peak;
        event_accept |-> $past(evt.peak_found);
    endproperty
    a_accept_peak: assert property (p_accept_peak)
        else $error("accept without a peak");
    property p_bus_ready;
        hreadyout;
    endproperty
    a_bus_ready: assert property (p_bus_ready)
        else $error("bus wait state inserted");
    property p_bus_okay;
        !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus error response");
endmodule
bind paux_top paux_asserts chk (
    .hclk(hclk), .hresetn(hresetn), .evt(evt), .hreadyout(hreadyout),
    .hresp(hresp), .win_out(win_out),
    .input_count_pulse(input_count_pulse), .event_accept(event_accept)
);

/* File: verif/paux_gate_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// external gating logic
// ****************************************************************
module paux_gate_model (
    // clock
    input wire logic  hclk,
    // command from bench
    input wire logic  gate_cmd,
    // pins toward the block
    output logic [1:0] aux_in
);
    initial aux_in = 2'b00;
    always @(posedge hclk) begin
        aux_in[0] <= gate_cmd;
        // unrouted line toggles so no stale level can pass as valid
        aux_in[1] <= ~aux_in[1];
    end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import paux_pkg::*;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic           hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [7:0]     haddr, win_out;
    logic [1:0]     htrans, aux_in, aux_out;
    logic [31:0]    hwdata, hrdata, seed, n;
    logic           input_count_pulse, event_accept, irq, gate_cmd;
    logic           rd_dp, pk, pk_d1, pk_d2, acc_cap;
    paux_event_type evt;
    int             bad_count, compares, cycles;
    logic [31:0]    rd_q[$];
    logic [8:0]     ev_q[$];
    paux_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .evt(evt),
        .aux_in(aux_in), .aux_out(aux_out), .win_out(win_out),
        .input_count_pulse(input_count_pulse),
        .event_accept(event_accept), .irq(irq)
    );
    paux_gate_model far (.hclk(hclk), .gate_cmd(gate_cmd), .aux_in(aux_in));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("counts: %0d compares, %0d mismatches", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rd_dp  <= ~w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_dp  <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    function automatic logic [15:0] lo(input int i);
        return 16'(i * 32'h2000);
    endfunction
    // neighbouring windows share one boundary level
    function automatic logic [15:0] hi(input int i);
        return (i == 7) ? 16'hffff : 16'(i * 32'h2000 + 32'h2000);
    endfunction
    task automatic hit_peak(input logic [15:0] lvl, input logic acc);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < NUM_WIN; i++)
            m[i] = (lvl >= lo(i)) && (lvl <= hi(i));
        ev_q.push_back({acc, m});
        @(posedge hclk);
        evt.fast_hit <= 1'b1;
        @(posedge hclk);
        evt.fast_hit <= 1'b0;
        repeat (3) @(posedge hclk);
        evt.peak_found <= 1'b1;
        evt.peak_level <= lvl;
        pk <= 1'b1;
        @(posedge hclk);
        evt.peak_found <= 1'b0;
        pk <= 1'b0;
        repeat (14) @(posedge hclk);
    endtask
    // ****************************************************************
    // result watcher and timeout
    // ****************************************************************
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            wrap_up();
        end
        if (rd_dp === 1'b1 && rd_q.size() > 0)
            check(hrdata, rd_q.pop_front());
        if (pk_d2 && ev_q.size() > 0)
            check({acc_cap, win_out}, ev_q.pop_front());
        if (pk_d1)
            acc_cap <= event_accept;
        pk_d2 <= pk_d1;
        pk_d1 <= pk;
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {hresetn, hsel, hwrite, rd_dp, pk, pk_d1, pk_d2} = 7'h0;
        {haddr, htrans, hwdata, gate_cmd, acc_cap} = 44'h0;
        evt = '0;
        seed = 32'hffe899dd;
        {bad_count, compares, cycles} = {32'sd0, 32'sd0, 32'sd0};
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_THR_BASE, 32'hffff_0000);
        rd(8'h40, 32'h0);
        bus(ADDR_CTRL, 1'b1, 32'h0060_1401);
        for (int i = 0; i < NUM_WIN; i++)
            bus(ADDR_THR_BASE + 8'(4 * i), 1'b1, {hi(i), lo(i)});
        bus(ADDR_IRQ_MASK, 1'b1, 32'h1);
        $display("setup test done");
        hit_peak(16'h2000, 1'b1);
        hit_peak(16'hffff, 1'b1);
        hit_peak(16'h0000, 1'b1);
        repeat (6) hit_peak(16'($random(seed)), 1'b1);
        check(irq, 1'b1);
        $display("window test done");
        bus(ADDR_AUXSEL, 1'b1, {22'h0, PAUX_IN_NONE, PAUX_IN_GATE,
                                 PAUX_OUT_DETRST, PAUX_OUT_COUNT});
        for (int k = 0; k < 4; k++) begin
            gate_cmd <= k[0];
            hit_peak(16'($random(seed)), k[0]);
        end
        rd(ADDR_IRQ_STAT, 32'h3);
        bus(ADDR_IRQ_STAT, 1'b1, 32'h3);
        rd(ADDR_IRQ_STAT, 32'h0);
        repeat (2) @(posedge hclk);
        check(irq, 1'b0);
        $display("gate test done");
        evt.fast_hit <= 1'b1;
        @(posedge hclk);
        evt.fast_hit <= 1'b0;
        repeat (2) @(posedge hclk);
        check(aux_out[0], 1'b1);
        @(posedge hclk);
        check(aux_out[0], 1'b0);
        repeat (12) @(posedge hclk);
        for (int k = 0; k < 4; k++) begin
            evt.fast_hit <= ~k[0];
            @(posedge hclk);
        end
        repeat (12) @(posedge hclk);
        rd(ADDR_IRQ_STAT, 32'h4);
        bus(ADDR_IRQ_STAT, 1'b1, 32'h4);
        $display("pile-up test done");
        evt.preamp_reset <= 1'b1;
        @(posedge hclk);
        evt.preamp_reset <= 1'b0;
        n = 32'h0;
        repeat (60) begin
            @(posedge hclk);
            n = n + 32'(aux_out[1]);
        end
        check(n, 32'd20);
        rd(ADDR_IRQ_STAT, 32'h8);
        bus(ADDR_IRQ_MASK, 1'b1, 32'h8);
        repeat (2) @(posedge hclk);
        check(irq, 1'b1);
        bus(ADDR_IRQ_STAT, 1'b1, 32'h8);
        repeat (2) @(posedge hclk);
        check(irq, 1'b0);
        $display("detector reset test done");
        bus(ADDR_CTRL, 1'b1, 32'h0060_1400);
        evt.fast_hit <= 1'b1;
        @(posedge hclk);
        evt.fast_hit <= 1'b0;
        evt.peak_found <= 1'b1;
        evt.peak_level <= 16'h3000;
        @(posedge hclk);
        evt.peak_found <= 1'b0;
        n = 32'h0;
        repeat (12) begin
            @(posedge hclk);
            n = n + 32'(win_out[1]);
        end
        check(n, 32'(WIN_CYC20));
        $display("slow clock test done");
        wrap_up();
    end
endmodule
